// File: dv/test_usb_boot_eeprom_loader.sv
/* Self-checking bench of the boot loader: boots from several EEPROM images.
   Assumes the EEPROM model and an APB master driven from here. */
`default_nettype none
module test_usb_boot_eeprom_loader;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, usb_configured = 0, en = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, ee_pull, usb_connect, use_default_desc, irq, e;
    logic [2:0] st = 3'h0;
    logic [3:0] raw = 4'h0, pins;
    logic [7:0] ifc, rdat;
    logic [7:0] id [0:5];
    logic [8:0] ra = 9'h000;
    int err_count = 0, n_checks = 0, seed = 32'h46db;
    wire scl_w = scl_oe ? scl_o : 1'b1;
    wire sda_w = (sda_oe ? sda_o : 1'b1) && !ee_pull;
    always #25 clk = ~clk;
    ubl_loader ubl_loader_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .eeprom_address_straps(st),
        .fifo_flags_raw(raw), .fifo_flag_pins(pins), .interface_config(ifc), .usb_connect(usb_connect),
        .use_default_desc(use_default_desc), .usb_configured(usb_configured), .enumeration_done_irq(irq),
        .desc_rd_addr(ra), .desc_rd_data(rdat));
    ubl_ee_model ubl_ee_model_i (.scl(scl_w), .sda(sda_w), .en(en), .st(st), .pull(ee_pull));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [3:0] exp_pins(input logic [3:0] f, input logic [7:0] p);
        return f ^ ~p[3:0];
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task results;
        $display("Mismatches %0d, checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task boot(input logic [2:0] s, input logic p, input logic [7:0] m0, input logic [7:0] m1, input logic [15:0] len);
        logic g0, ld, dflt;
        logic [7:0] pol;
        int n;
        for (int k = 0; k < 512; k++) ubl_ee_model_i.mem[k] = 8'($random(seed));
        ubl_ee_model_i.mem[0] = m0;
        ubl_ee_model_i.mem[3] = m1;
        {ubl_ee_model_i.mem[5], ubl_ee_model_i.mem[4]} = len;
        ubl_ee_model_i.n_addr = 0;
        g0 = p && m0 == ubl_pkg::MARKER;
        ld = g0 && m1 == ubl_pkg::MARKER && len != 0 && len <= ubl_pkg::DESC_MAX;
        dflt = !ld || len == ubl_pkg::DEFAULT_LEN;
        pol = g0 ? ubl_ee_model_i.mem[2] : ubl_pkg::POLAR_RST;
        st <= s;
        en <= p;
        usb_configured <= 0;
        sys_rst <= 1;
        repeat (5) @(posedge clk);
        sys_rst <= 0;
        r = 0;
        for (int i = 0; i < 3000 && !(r[3] | r[4]); i++) begin
            repeat (20) @(posedge clk);
            apb(0, 12'h008, 0);
        end
        chk(r[5:0], {ld && len == ubl_pkg::DEFAULT_LEN, ld, !ld, ld, g0, p});
        chk(ubl_ee_model_i.n_addr, p ? (s == ubl_pkg::STRAP_TWO ? 2 : 1) : 0);
        chk(ifc, g0 ? ubl_ee_model_i.mem[1] : ubl_pkg::IFCFG_RST);
        apb(0, 12'h010, 0);
        chk(r, {24'h0, pol});
        @(posedge clk);
        raw <= 4'($random(seed));
        repeat (2) @(posedge clk);
        chk(pins, exp_pins(raw, pol));
        if (!dflt) for (int k = 0; k < len; k++) begin
            @(posedge clk);
            ra <= 9'(k);
            repeat (2) @(posedge clk);
            chk(rdat, ubl_ee_model_i.mem[6 + k]);
        end
        for (int k = 0; k < 6; k++) id[k] = ld ? ubl_ee_model_i.mem[6 + k] : 8'($random(seed));
        if (!ld) begin
            chk(usb_connect, 0);
            apb(1, 12'h0C0, 32'hF5);
            apb(1, 12'h0C0, 32'h01);
            apb(1, 12'h0C0, 6);
            apb(1, 12'h0C0, 0);
            for (int k = 0; k < 6; k++) apb(1, 12'h0C0, {24'h0, id[k]});
            for (int i = 0; i < 50 && usb_connect !== 1'b1; i++) @(posedge clk);
        end
        chk({usb_connect, use_default_desc}, {1'b1, dflt});
        if (dflt) begin
            apb(0, 12'h00C, 0);
            chk(r, {id[3], id[2], id[1], id[0]});
            apb(0, 12'h008, 0);
            chk(r[31:16], {id[5], id[4]});
        end
        @(posedge clk);
        usb_configured <= 1;
        n = 0;
        repeat (4) begin
            @(posedge clk);
            n += irq;
        end
        chk(n, 1);
        apb(1, 12'h004, 32'h5A);
        apb(0, 12'h004, 0);
        chk(r, 32'h5A);
        apb(1, 12'h010, 32'hA5);
        apb(0, 12'h010, 0);
        chk(r, 32'hA5);
        apb(0, 12'h100, 0);
        chk(e, 1);
        chk(r, 0);
    endtask
    initial begin
        boot(3'h1, 1, 8'hC4, 8'hC4, 16'h0006);
        boot(3'h0, 1, 8'hC4, 8'hC4, 16'h0007);
        boot(3'h0, 1, 8'hC4, 8'h55, 16'h0006);
        boot(3'h1, 0, 8'hC4, 8'hC4, 16'h0006);
        boot(3'h0, 1, 8'h3C, 8'hC4, 16'h0006);
        boot(3'h0, 1, 8'hC4, 8'hC4, 16'h01F5);
        results;
    end
    initial begin
        repeat (120000) @(posedge clk);
        err_count++;
        results;
    end
endmodule // test_usb_boot_eeprom_loader
`default_nettype wire

// File: dv/ubl_ee_model.sv
/* Serial EEPROM partner: two-wire slave with a 512-byte array.
   Assumes the bench resolves pulled-up SCL and SDA wires. */
`default_nettype none
module ubl_ee_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic en,
    input wire logic [2:0] st,
    output logic pull
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:511];
    logic [7:0] sh;
    logic rd = 0;
    logic go = 0;
    logic act = 0;
    int bc;
    int ph;
    int ptr = 0;
    int n_addr = 0;
    initial pull = 0;
    always @(sda) if (scl === 1'b1) begin
        act = !sda;
        bc = -1; // The SCL fall that follows START carries no bit
        ph = 0;
        rd = 0;
        go = 0;
        pull = 0;
    end
    always @(posedge scl) if (act) begin
        if (bc < 8) sh = {sh[6:0], sda};
        else if (rd && sda) rd = 0;
        else if (rd) ptr++;
    end
    always @(negedge scl) if (act) begin
        bc = (bc == 8) ? 0 : bc + 1;
        pull = 0;
        if (bc == 0 && go) begin
            rd = 1;
            go = 0;
        end
        if (bc == 8 && !rd && ph == 0 && en && sh[7:1] == {ubl_pkg::EE_DEV_TYPE, st}) begin
            pull = 1;
            go = sh[0];
            ph = 1;
            if (!sh[0]) ptr = 0;
        end else if (bc == 8 && !rd && ph == 1) begin
            ptr = {ptr[7:0], sh};
            n_addr++;
            pull = 1;
        end else if (bc < 8 && rd) pull = !mem[ptr[8:0]][7 - bc];
    end
endmodule // ubl_ee_model
`default_nettype wire

// File: hw/ubl_desc_mem.sv
/*
 * Descriptor store: 512 bytes, one write port, registered read port.
 * Assumes writer and reader share the loader clock.
 */
`default_nettype none
module ubl_desc_mem (
    input wire logic clk,
    input wire logic sys_rst,
    input wire ubl_pkg::ubl_memwr_t wr,
    input wire logic [ubl_pkg::MEM_AW-1:0] rd_addr,
    output var logic [7:0] rd_data
);
    logic [7:0] mem [0:(1<<ubl_pkg::MEM_AW)-1];

    always_ff @(posedge clk) begin
        if (wr.en) begin
            mem[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // ubl_desc_mem
`default_nettype wire

// File: hw/ubl_loader.sv
/*
 * Power-up configuration loader: reads a serial EEPROM over a two-wire
 * bus, loads configuration and descriptor, or waits for the master.
 * Assumes pulled-up open-drain SCL/SDA and an APB master for registers.
 */
`default_nettype none
// Function
// (RQ1) At power-up probe the serial bus for an EEPROM and boot from it.
// (RQ2) Byte 0 equal marker: bytes 1 and 2 go to interface and polarity registers.
// (RQ3) Byte 3 equal marker: enumerate from EEPROM descriptor, then signal enumeration done.
// (RQ4) No EEPROM: wait for master descriptor before connecting and enumerating.
// (RQ5) Byte 3 not marker: skip EEPROM descriptor, wait for the master.
// (RQ6) Descriptor length is bytes 4 and 5, low byte first.
// (RQ7) Descriptor starts at byte 6, up to 500 bytes accepted.
// (RQ8) Length six: bytes 6 to 11 are IDs, use built-in default descriptor.
// (RQ9) Master may supply only the IDs to choose default enumeration.
// (RQ10) Straps 000 send one address byte, 001 send two.
// (RQ11) Polarity byte sets flag pin levels; config byte sets interface register.
// (RQ12) Master writes descriptor register with length six then the IDs.
// (RQ13) Bad first marker: keep registers at defaults and wait for master.
// (RQ14) Sequential read from address zero, one byte per transfer until done.
module ubl_loader (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [2:0] eeprom_address_straps,
    input wire logic [3:0] fifo_flags_raw,
    output logic [3:0] fifo_flag_pins,
    output logic [7:0] interface_config,
    output logic usb_connect,
    output logic use_default_desc,
    input wire logic usb_configured,
    output logic enumeration_done_irq,
    input wire logic [ubl_pkg::MEM_AW-1:0] desc_rd_addr,
    output logic [7:0] desc_rd_data
);
    localparam logic [5:0] QTR_LAST = 6'(ubl_pkg::QTR_CYC - 1);

    ubl_pkg::ubl_st_t st;
    ubl_pkg::ubl_ph_t ph;
    ubl_pkg::ubl_memwr_t memwr;
    ubl_pkg::ubl_status_t status;
    logic [5:0] div;
    logic qtick;
    logic [1:0] q;
    logic [2:0] bits;
    logic [7:0] sh;
    logic [15:0] byte_idx;
    logic [15:0] desc_len;
    logic [47:0] ids;
    logic [9:0] hcnt;
    logic [7:0] flag_polarity;
    logic addr_left, ack_bad, more, next_more, byte_done, slot_end;
    logic eeprom_found, cfg_loaded, load_complete, host_done, conf_d;
    logic [2:0] straps, st1, st2, st3, strap_clean;
    logic sd1, sd2, sd3, sda_clean;
    logic scl_hi, sda_low, wr_go, wr_desc;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Quarter-bit enable for the two-wire bus
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div <= 6'h00;
            qtick <= 1'b0;
        end else begin
            qtick <= (div == QTR_LAST);
            div <= (div == QTR_LAST) ? 6'h00 : div + 6'h01;
        end
    end

    // Pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {sd1, sd2, sd3, sda_clean} <= 4'hF;
            {st1, st2, st3, strap_clean} <= 12'h000;
        end else begin
            sd1 <= sda_i;
            sd2 <= sd1;
            sd3 <= sd2;
            if (sd2 == sd3) begin
                sda_clean <= sd3;
            end
            st1 <= eeprom_address_straps;
            st2 <= st1;
            st3 <= st2;
            if (st2 == st3) begin
                strap_clean <= st3;
            end
        end
    end

    assign slot_end = qtick && (q == 2'h3);
    assign byte_done = slot_end && (st == ubl_pkg::ST_RX) && (bits == 3'h0);

    // Decide per received byte whether the read goes on
    always_comb begin
        next_more = 1'b0;
        if (byte_idx == ubl_pkg::IDX_MARK0 || byte_idx == ubl_pkg::IDX_MARK1) begin
            next_more = (sh == ubl_pkg::MARKER); // RQ13 RQ5
        end else if (byte_idx < ubl_pkg::IDX_LEN_HI) begin
            next_more = 1'b1;
        end else if (byte_idx == ubl_pkg::IDX_LEN_HI) begin
            next_more = ({sh, desc_len[7:0]} != 16'h0000) && ({sh, desc_len[7:0]} <= ubl_pkg::DESC_MAX); // RQ7
        end else begin
            next_more = (byte_idx - 16'h0005) < desc_len; // RQ14
        end
    end

    // Two-wire master sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= ubl_pkg::ST_IDLE;
            ph <= ubl_pkg::PH_DEVW;
            q <= 2'h0;
            bits <= 3'h0;
            sh <= 8'h00;
            byte_idx <= 16'h0000;
            addr_left <= 1'b0;
            ack_bad <= 1'b0;
            more <= 1'b0;
            eeprom_found <= 1'b0;
            straps <= 3'h0;
        end else if (st == ubl_pkg::ST_HOST) begin
            if (host_done) begin
                st <= ubl_pkg::ST_RUN; // RQ4
            end
        end else if (qtick) begin
            q <= q + 2'h1;
            if (q == 2'h2 && st == ubl_pkg::ST_RX) begin
                sh <= {sh[6:0], sda_clean};
            end
            if (q == 2'h2 && st == ubl_pkg::ST_ACKIN) begin
                ack_bad <= sda_clean;
            end
            if (q == 2'h3) begin
                case (st)
                    ubl_pkg::ST_IDLE: begin
                        straps <= strap_clean;
                        st <= ubl_pkg::ST_START; // RQ1
                    end
                    ubl_pkg::ST_START: begin
                        sh <= {ubl_pkg::EE_DEV_TYPE, straps, ph == ubl_pkg::PH_DEVR};
                        bits <= 3'h7;
                        st <= ubl_pkg::ST_TX;
                    end
                    ubl_pkg::ST_TX: begin
                        if (bits == 3'h0) begin
                            st <= ubl_pkg::ST_ACKIN;
                        end else begin
                            bits <= bits - 3'h1;
                            sh <= {sh[6:0], 1'b0};
                        end
                    end
                    ubl_pkg::ST_ACKIN: begin
                        bits <= 3'h7;
                        sh <= 8'h00; // RQ14
                        if (ack_bad) begin
                            st <= ubl_pkg::ST_STOP; // RQ4
                        end else if (ph == ubl_pkg::PH_DEVW) begin
                            eeprom_found <= 1'b1; // RQ1
                            ph <= ubl_pkg::PH_ADDR;
                            addr_left <= (straps == ubl_pkg::STRAP_TWO); // RQ10
                            st <= ubl_pkg::ST_TX;
                        end else if (ph == ubl_pkg::PH_ADDR) begin
                            addr_left <= 1'b0;
                            if (addr_left) begin
                                st <= ubl_pkg::ST_TX; // RQ10
                            end else begin
                                ph <= ubl_pkg::PH_DEVR;
                                st <= ubl_pkg::ST_START;
                            end
                        end else begin
                            ph <= ubl_pkg::PH_DATA;
                            st <= ubl_pkg::ST_RX;
                        end
                    end
                    ubl_pkg::ST_RX: begin
                        if (bits == 3'h0) begin
                            more <= next_more;
                            st <= ubl_pkg::ST_ACKOUT;
                        end else begin
                            bits <= bits - 3'h1;
                        end
                    end
                    ubl_pkg::ST_ACKOUT: begin
                        if (more) begin
                            byte_idx <= byte_idx + 16'h0001; // RQ14
                            bits <= 3'h7;
                            st <= ubl_pkg::ST_RX;
                        end else begin
                            st <= ubl_pkg::ST_STOP;
                        end
                    end
                    ubl_pkg::ST_STOP: begin
                        st <= load_complete ? ubl_pkg::ST_RUN : ubl_pkg::ST_HOST; // RQ3 RQ5 RQ13
                    end
                    default: begin
                        st <= st;
                    end
                endcase
            end
        end
    end

    // Bus line levels per quarter of the bit slot
    always_comb begin
        scl_hi = (q == 2'h1) || (q == 2'h2);
        sda_low = 1'b0;
        case (st)
            ubl_pkg::ST_START: sda_low = (q >= 2'h2);
            ubl_pkg::ST_TX: sda_low = !sh[7];
            ubl_pkg::ST_ACKOUT: sda_low = more;
            ubl_pkg::ST_STOP: begin
                scl_hi = (q != 2'h0);
                sda_low = (q < 2'h2);
            end
            ubl_pkg::ST_RX, ubl_pkg::ST_ACKIN: sda_low = 1'b0;
            default: scl_hi = 1'b1;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_oe <= !scl_hi;
            sda_oe <= sda_low;
        end
    end

    // Descriptor bytes from EEPROM or from the master
    assign wr_go = psel && penable && pready && pwrite;
    assign wr_desc = wr_go && (paddr == ubl_pkg::reg_addr(ubl_pkg::REG_DESC)) && (st == ubl_pkg::ST_HOST);

    always_comb begin
        memwr = '0;
        if (byte_done && byte_idx >= ubl_pkg::IDX_DESC) begin
            memwr.en = 1'b1; // RQ7
            memwr.addr = 9'(byte_idx - ubl_pkg::IDX_DESC);
            memwr.data = sh;
        end else if (wr_desc && hcnt >= 10'h002) begin
            memwr.en = 1'b1; // RQ12
            memwr.addr = 9'(hcnt - 10'h002);
            memwr.data = pwdata[7:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            desc_len <= 16'h0000;
            hcnt <= 10'h000;
            ids <= 48'h0;
            load_complete <= 1'b0;
            host_done <= 1'b0;
        end else begin
            if (byte_done && byte_idx == ubl_pkg::IDX_LEN_LO) begin
                desc_len[7:0] <= sh; // RQ6
            end
            if (byte_done && byte_idx == ubl_pkg::IDX_LEN_HI) begin
                desc_len[15:8] <= sh; // RQ6
            end
            if (byte_done && byte_idx >= ubl_pkg::IDX_DESC && !next_more) begin
                load_complete <= 1'b1; // RQ3
            end
            if (wr_desc) begin
                hcnt <= hcnt + 10'h001;
                if (hcnt == 10'h000) begin
                    desc_len[7:0] <= pwdata[7:0];
                end else if (hcnt == 10'h001) begin
                    desc_len[15:8] <= pwdata[7:0];
                    if ({pwdata[7:0], desc_len[7:0]} == 16'h0000 || {pwdata[7:0], desc_len[7:0]} > ubl_pkg::DESC_MAX) begin
                        hcnt <= 10'h000;
                    end
                end else if (16'(hcnt) == desc_len + 16'h0001) begin
                    host_done <= 1'b1; // RQ4 RQ9
                end
            end
            if (memwr.en && memwr.addr < ubl_pkg::ID_BYTES) begin
                ids[memwr.addr[2:0]*8 +: 8] <= memwr.data; // RQ8
            end
        end
    end

    ubl_desc_mem u_mem (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr(memwr),
        .rd_addr(desc_rd_addr),
        .rd_data(desc_rd_data)
    );

    // USB connect, default descriptor choice and enumeration-done pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            usb_connect <= 1'b0;
            use_default_desc <= 1'b0;
            conf_d <= 1'b0;
            enumeration_done_irq <= 1'b0;
        end else begin
            usb_connect <= (st == ubl_pkg::ST_RUN); // RQ3 RQ4
            use_default_desc <= (st == ubl_pkg::ST_RUN) && (desc_len == ubl_pkg::DEFAULT_LEN); // RQ8
            conf_d <= usb_configured;
            enumeration_done_irq <= usb_configured && !conf_d && usb_connect; // RQ3
        end
    end

    // Configuration registers and flag pin polarity
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            interface_config <= ubl_pkg::IFCFG_RST;
            flag_polarity <= ubl_pkg::POLAR_RST;
            cfg_loaded <= 1'b0;
            fifo_flag_pins <= 4'h0;
        end else begin
            if (byte_done && byte_idx == ubl_pkg::IDX_IFCFG) begin
                interface_config <= sh; // RQ2 RQ11
            end else if (wr_go && paddr == ubl_pkg::reg_addr(ubl_pkg::REG_IFCFG)) begin
                interface_config <= pwdata[7:0];
            end
            if (byte_done && byte_idx == ubl_pkg::IDX_POLAR) begin
                flag_polarity <= sh; // RQ2
                cfg_loaded <= 1'b1;
            end else if (wr_go && paddr == ubl_pkg::reg_addr(ubl_pkg::REG_POLAR)) begin
                flag_polarity <= pwdata[7:0];
            end
            fifo_flag_pins <= fifo_flags_raw ^ ~flag_polarity[3:0]; // RQ11
        end
    end

    // APB slave: one wait-free access, error on unmapped address
    always_comb begin
        status = '0;
        status.did = ids[47:32];
        status.use_default = use_default_desc;
        status.connect = usb_connect;
        status.host_wait = (st == ubl_pkg::ST_HOST);
        status.desc_loaded = load_complete || host_done;
        status.cfg_loaded = cfg_loaded;
        status.eeprom_found = eeprom_found;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (psel && !penable) begin
                if (paddr == ubl_pkg::reg_addr(ubl_pkg::REG_IFCFG)) begin
                    prdata <= {24'h0, interface_config};
                end else if (paddr == ubl_pkg::reg_addr(ubl_pkg::REG_POLAR)) begin
                    prdata <= {24'h0, flag_polarity};
                end else if (paddr == ubl_pkg::reg_addr(ubl_pkg::REG_STATUS)) begin
                    prdata <= status;
                end else if (paddr == ubl_pkg::reg_addr(ubl_pkg::REG_IDS)) begin
                    prdata <= ids[31:0];
                end else if (paddr != ubl_pkg::reg_addr(ubl_pkg::REG_DESC)) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    sequence s_pulse;
        enumeration_done_irq ##1 !enumeration_done_irq;
    endsequence
    property p_cfg_copy;
        byte_done && byte_idx == ubl_pkg::IDX_IFCFG |=> interface_config == $past(sh);
    endproperty
    a_cfg_copy: assert property (p_cfg_copy) else $error("config byte not copied"); // RQ2
    property p_bad_marker;
        byte_done && byte_idx == ubl_pkg::IDX_MARK0 && sh != ubl_pkg::MARKER |=> !more ##[1:400] st == ubl_pkg::ST_HOST;
    endproperty
    a_bad_marker: assert property (p_bad_marker) else $error("bad marker not ending load"); // RQ13
    property p_skip_desc;
        byte_done && byte_idx == ubl_pkg::IDX_MARK1 && sh != ubl_pkg::MARKER |=> !more;
    endproperty
    a_skip_desc: assert property (p_skip_desc) else $error("descriptor read despite bad marker"); // RQ5
    property p_len_hi;
        byte_done && byte_idx == ubl_pkg::IDX_LEN_HI |=> desc_len == {$past(sh), $past(desc_len[7:0])};
    endproperty
    a_len_hi: assert property (p_len_hi) else $error("length high byte wrong"); // RQ6
    property p_idx_step;
        slot_end && st == ubl_pkg::ST_ACKOUT && more |=> byte_idx == $past(byte_idx) + 16'h0001;
    endproperty
    a_idx_step: assert property (p_idx_step) else $error("read index not advancing by one"); // RQ14
    property p_connect_cause;
        $rose(usb_connect) |-> status.desc_loaded;
    endproperty
    a_connect_cause: assert property (p_connect_cause) else $error("connect without descriptor"); // RQ4
    property p_default;
        usb_connect && desc_len == ubl_pkg::DEFAULT_LEN |-> use_default_desc;
    endproperty
    a_default: assert property (p_default) else $error("default descriptor not chosen"); // RQ8
    property p_addr_bytes;
        st == ubl_pkg::ST_ACKIN && ph == ubl_pkg::PH_DEVW && slot_end && !ack_bad
            |=> addr_left == (straps == ubl_pkg::STRAP_TWO);
    endproperty
    a_addr_bytes: assert property (p_addr_bytes) else $error("address byte count wrong"); // RQ10
    property p_polarity;
        !sys_rst |=> fifo_flag_pins == ($past(fifo_flags_raw) ^ ~$past(flag_polarity[3:0]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("flag pin polarity wrong"); // RQ11
    property p_irq;
        $rose(usb_configured) && usb_connect |=> s_pulse;
    endproperty
    a_irq: assert property (p_irq) else $error("enumeration done pulse missing"); // RQ3
endmodule // ubl_loader
`default_nettype wire

// File: hw/ubl_pkg.sv
/*
 * Shared constants and types of the boot loader: timing, EEPROM layout,
 * register indices, reset values, states and carriers.
 * Assumes a single 20 MHz clock domain.
 */
`default_nettype none
package ubl_pkg;
    localparam int CLK_NS = 50;
    localparam int I2C_BIT_NS = 10000;
    localparam int QTR_CYC = I2C_BIT_NS / 4 / CLK_NS;
    localparam logic [7:0] MARKER = 8'hC4;
    localparam logic [3:0] EE_DEV_TYPE = 4'hA;
    localparam logic [2:0] STRAP_TWO = 3'h1;
    localparam logic [15:0] IDX_MARK0 = 16'h0000;
    localparam logic [15:0] IDX_IFCFG = 16'h0001;
    localparam logic [15:0] IDX_POLAR = 16'h0002;
    localparam logic [15:0] IDX_MARK1 = 16'h0003;
    localparam logic [15:0] IDX_LEN_LO = 16'h0004;
    localparam logic [15:0] IDX_LEN_HI = 16'h0005;
    localparam logic [15:0] IDX_DESC = 16'h0006;
    localparam logic [15:0] DESC_MAX = 16'h01F4;
    localparam logic [15:0] DEFAULT_LEN = 16'h0006;
    localparam logic [8:0] ID_BYTES = 9'h006;
    localparam logic [7:0] REG_IFCFG = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_IDS = 8'h03;
    localparam logic [7:0] REG_POLAR = 8'h04;
    localparam logic [7:0] REG_DESC = 8'h30;
    localparam logic [7:0] IFCFG_RST = 8'h00;
    localparam logic [7:0] POLAR_RST = 8'h00;
    localparam int MEM_AW = 9;

    typedef enum {ST_IDLE, ST_START, ST_TX, ST_ACKIN, ST_RX, ST_ACKOUT, ST_STOP, ST_HOST, ST_RUN} ubl_st_t;
    typedef enum {PH_DEVW, PH_ADDR, PH_DEVR, PH_DATA} ubl_ph_t;

    typedef struct packed {
        logic en;
        logic [MEM_AW-1:0] addr;
        logic [7:0] data;
    } ubl_memwr_t;

    typedef struct packed {
        logic [15:0] did;
        logic [9:0] pad;
        logic use_default;
        logic connect;
        logic host_wait;
        logic desc_loaded;
        logic cfg_loaded;
        logic eeprom_found;
    } ubl_status_t;

    function automatic logic [11:0] reg_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction
endpackage
`default_nettype wire
